/* File: rtl/clkrst_pkg.sv */
// shared constants and types for the clock, reset and power control block
package clkrst_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] SYSTEM_CLOCK_CONTROL_ADDR = 8'hd4;
  localparam logic [7:0] BASIC_TIMER_CONTROL_ADDR  = 8'hdc;
  localparam logic [7:0] STOP_ENABLE_CONTROL_ADDR  = 8'hd8;
  localparam logic [7:0] POWER_STATUS_ADDR         = 8'hd6;
  localparam logic [7:0] POWER_COMMAND_ADDR        = 8'hd7;

  // ==========================================================================
  // field positions and values
  localparam int          WAKE_EN_BIT      = 7;
  localparam int          DIV_LO_BIT       = 3;
  localparam logic [7:0]  SYSCLK_RESET     = 8'h80;
  localparam logic [7:0]  BASIC_TIMER_CONTROL_RESET      = 8'h00;
  localparam logic [3:0]  WDOG_OFF_PATTERN = 4'ha;
  localparam logic [7:0]  STOP_KEY         = 8'ha5;
  localparam logic [15:0] RESET_VECTOR     = 16'h0100;
  localparam logic [7:0]  CMD_STOP         = 8'h01;
  localparam logic [7:0]  CMD_IDLE         = 8'h02;

  // ==========================================================================
  // option encodings
  localparam logic [1:0] OSC_INT_RC = 2'h3;
  localparam logic [1:0] OSC_EXT_RC = 2'h2;
  localparam logic [1:0] OSC_XTAL   = 2'h0;

  // ==========================================================================
  // timing: stabilization wait in oscillator periods
  localparam int STAB_CYCLES_LOG2 = 19;
  localparam int STAB_CYCLES      = 1 << STAB_CYCLES_LOG2;
  localparam int CLK_PERIOD_NS    = 20;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_IDLE,
    PWR_STOP,
    PWR_WAKE
  } power_state_t;

  typedef struct packed {
    logic [7:0] adr;
    logic [7:0] dat;
    logic       we;
    logic       cyc;
    logic       stb;
    logic       sel;
  } wb_req_t;

  typedef struct packed {
    logic       cpu_rst;
    logic       periph_rst;
    logic       wdog_en;
    logic       ports_input;
    logic       irq_disable;
  } reset_ctl_t;

endpackage

/* File: rtl/cpu_clock_divider.sv */
// oscillator divider producing the cpu clock enable pulse
`timescale 1ns/10ps
module cpu_clock_divider (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] div_sel_i,
  input  wire logic       run_i,
  output logic            tick_o
);

  logic [3:0] count;
  logic [3:0] next_count;
  logic [3:0] limit;

  // ==========================================================================
  // divide select decode
  always_comb
  begin
    unique case (div_sel_i)
      2'h0: limit = 4'hf;     // divide by 16
      2'h1: limit = 4'h7;     // divide by 8
      2'h2: limit = 4'h1;     // divide by 2
      2'h3: limit = 4'h0;     // undivided
    endcase
  end

  // counter next value
  always_comb
  begin
    next_count = count;
    if (!run_i)
      next_count = 4'h0;
    else if (count >= limit)
      next_count = 4'h0;
    else
      next_count = count + 4'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count <= 4'h0;
    else
      count <= next_count;
  end

  // one pulse per divided period
  assign tick_o = run_i && (count >= limit);

endmodule

/* File: rtl/clock_reset_power_control.sv */
// clock selection, power-down and reset sequencing for an 8-bit controller
// Summary of operation
// - two option bits pick internal rc, external rc or crystal source
// - internal oscillator frees both oscillator pins as general i/o
// - cpu clock is oscillator undivided, or divided by 2, 8 or 16
// - clock control bit 7 enables stop wake-up by external interrupt
// - reset enables interrupt wake-up and selects oscillator divided by 16
// - stop freezes oscillator, cpu and peripherals, keeping register contents
// - stop ends only on reset or either filtered external interrupt
// - idle gates clock from cpu only; interrupt logic and timer run
// - idle keeps cpu state and ends on reset or any interrupt
// - option bit selects low-voltage reset or pin; pin then is i/o
// - reset comes from power-on, pin, watchdog, low-voltage detector or a stop command without the stop key
// - external reset pin is synchronised before internal use
// - any reset loads every control register with its default
// - watchdog overflow without refresh asserts internal reset
// - low-voltage detector holds reset while active, start after release
// - writing 1010 to basic timer upper nibble disables watchdog reset
// - reset pulse is produced when the reset pin rises
// - reset disables interrupts, enables watchdog, ports input, loads defaults
// - pc takes reset location; vector fetched after stabilization
// - reset clears divide bits to 00, giving divide by 16
// - interrupt exit from stop or idle keeps divide bits
`timescale 1ns/10ps
module clock_reset_power_control #(
  parameter int STAB_WAIT = clkrst_pkg::STAB_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [7:0]  dat_i,
  input  wire logic        sel_i,
  output logic [7:0]       dat_o,
  output logic             ack_o,
  // option bits and reset sources
  input  wire logic [1:0]  osc_option_i,
  input  wire logic        lvr_option_i,
  input  wire logic        external_reset_pin_n_i,
  input  wire logic        low_voltage_detector_reset_i,
  input  wire logic        wdog_overflow_i,
  input  wire logic        external_irq_line_a_i,
  input  wire logic        external_irq_line_b_i,
  input  wire logic        internal_irq_i,
  // oscillator and clock outputs
  output logic             osc_enable_o,
  output logic             osc_pins_gpio_o,
  output logic             reset_pin_gpio_o,
  output logic             cpu_clk_en_o,
  output logic             periph_clk_en_o,
  output logic             stab_done_o,
  // reset outputs
  output clkrst_pkg::reset_ctl_t reset_ctl_o,
  output logic [15:0]      reset_pc_o,
  output logic             wdog_reset_en_o
);

  // ==========================================================================
  // declarations
  clkrst_pkg::wb_req_t      req;
  clkrst_pkg::power_state_t state;
  clkrst_pkg::power_state_t next_state;
  logic [7:0]  sysclk;
  logic [7:0]  next_sysclk;
  logic [7:0]  basic_timer_control;
  logic [7:0]  next_basic_timer_control;
  logic [7:0]  stop_key;
  logic [7:0]  next_stop_key;
  logic        ack;
  logic        next_ack;
  logic [7:0]  rdata;
  logic [7:0]  next_rdata;
  logic        pin_meta;
  logic        pin_sync;
  logic        pin_last;
  logic        pin_pulse;
  logic        hold_rst;
  logic        next_hold_rst;
  logic [19:0] stab_cnt;
  logic [19:0] next_stab_cnt;
  logic        stab_done;
  logic        next_stab_done;
  logic        cpu_hold;
  logic        next_cpu_hold;
  logic        sys_rst;
  logic        bad_stop;
  logic        next_bad_stop;
  logic        wr;
  logic        rd;
  logic        cmd_stop;
  logic        cmd_idle;
  logic        ext_irq;
  logic        tick;

  assign req = '{adr: adr_i, dat: dat_i, we: we_i, cyc: cyc_i, stb: stb_i, sel: sel_i};

  // ==========================================================================
  // bus strobes, one access per request
  assign wr       = req.cyc && req.stb && req.we && req.sel && !ack;
  assign rd       = req.cyc && req.stb && !req.we && !ack;
  assign cmd_stop = wr && (req.adr == clkrst_pkg::POWER_COMMAND_ADDR)
                    && (req.dat == clkrst_pkg::CMD_STOP);
  assign cmd_idle = wr && (req.adr == clkrst_pkg::POWER_COMMAND_ADDR)
                    && (req.dat == clkrst_pkg::CMD_IDLE);
  assign ext_irq  = external_irq_line_a_i || external_irq_line_b_i;

  // ==========================================================================
  // reset pin synchroniser and rising-edge detect
  // flops reset to the pin's idle high level, so no false rise after reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      pin_last <= 1'b1;
    end
    else
    begin
      pin_meta <= external_reset_pin_n_i;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // pulse on pin release, only when the pin is the reset source
  assign pin_pulse = !lvr_option_i && pin_sync && !pin_last;

  // ==========================================================================
  // held reset: power-on, pin low, or low-voltage detector active
  always_comb
  begin
    next_hold_rst = 1'b0;
    if (lvr_option_i)
      next_hold_rst = low_voltage_detector_reset_i;
    else
      next_hold_rst = !pin_sync;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hold_rst <= 1'b1;
    else
      hold_rst <= next_hold_rst;
  end

  // watchdog reset gated by the disable pattern in the basic timer register
  assign wdog_reset_en_o = (basic_timer_control[7:4] != clkrst_pkg::WDOG_OFF_PATTERN);

  // combined system reset from every source
  assign sys_rst = rst_i || hold_rst || pin_pulse || bad_stop
                   || (wdog_overflow_i && wdog_reset_en_o);

  // ==========================================================================
  // register file next values
  always_comb
  begin
    next_sysclk   = sysclk;
    next_basic_timer_control    = basic_timer_control;
    next_stop_key = stop_key;
    if (wr && req.adr == clkrst_pkg::SYSTEM_CLOCK_CONTROL_ADDR)
      next_sysclk = req.dat & 8'h98;    // wake enable and divide bits
    if (wr && req.adr == clkrst_pkg::BASIC_TIMER_CONTROL_ADDR)
      next_basic_timer_control = req.dat;
    if (wr && req.adr == clkrst_pkg::STOP_ENABLE_CONTROL_ADDR)
      next_stop_key = req.dat;
  end

  // defaults on every reset; divide bits untouched by interrupt wake
  always_ff @(posedge clk_i)
  begin
    if (sys_rst)
    begin
      sysclk   <= clkrst_pkg::SYSCLK_RESET;
      basic_timer_control    <= clkrst_pkg::BASIC_TIMER_CONTROL_RESET;
      stop_key <= 8'h00;
    end
    else
    begin
      sysclk   <= next_sysclk;
      basic_timer_control    <= next_basic_timer_control;
      stop_key <= next_stop_key;
    end
  end

  // ==========================================================================
  // bus answer, one cycle after the request, dropped the cycle after
  always_comb
  begin
    next_ack   = (req.cyc && req.stb) && !ack;
    next_rdata = 8'h00;
    if (rd)
    begin
      unique case (req.adr)
        clkrst_pkg::SYSTEM_CLOCK_CONTROL_ADDR: next_rdata = sysclk;
        clkrst_pkg::BASIC_TIMER_CONTROL_ADDR:  next_rdata = basic_timer_control;
        clkrst_pkg::STOP_ENABLE_CONTROL_ADDR:  next_rdata = stop_key;
        clkrst_pkg::POWER_STATUS_ADDR:
          next_rdata = {5'h00, stab_done, 2'(state)};
        default:                               next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack   <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      ack   <= next_ack;
      rdata <= next_rdata;
    end
  end

  assign ack_o = ack;
  assign dat_o = rdata;

  // ==========================================================================
  // power state machine
  always_comb
  begin
    next_state    = state;
    next_bad_stop = 1'b0;
    unique case (state)
      clkrst_pkg::PWR_RUN:
      begin
        if (cmd_stop && stop_key == clkrst_pkg::STOP_KEY)
          next_state = clkrst_pkg::PWR_STOP;
        else if (cmd_stop)
          next_bad_stop = 1'b1;
        else if (cmd_idle)
          next_state = clkrst_pkg::PWR_IDLE;
      end
      clkrst_pkg::PWR_IDLE:
        if (ext_irq || internal_irq_i)
          next_state = clkrst_pkg::PWR_RUN;
      clkrst_pkg::PWR_STOP:
        if (ext_irq && sysclk[clkrst_pkg::WAKE_EN_BIT])
          next_state = clkrst_pkg::PWR_WAKE;
      clkrst_pkg::PWR_WAKE:
        if (stab_done)
          next_state = clkrst_pkg::PWR_RUN;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst)
    begin
      state    <= clkrst_pkg::PWR_WAKE;   // wait stabilization after reset
      bad_stop <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      bad_stop <= next_bad_stop;
    end
  end

  // ==========================================================================
  // stabilization counter, length from the basic timer setting
  always_comb
  begin
    next_stab_cnt  = stab_cnt;
    next_stab_done = stab_done;
    if (state == clkrst_pkg::PWR_WAKE)
    begin
      if (stab_cnt >= 20'(STAB_WAIT - 1) >> basic_timer_control[3:2])
        next_stab_done = 1'b1;
      else
        next_stab_cnt = stab_cnt + 20'h1;
    end
    else if (next_state == clkrst_pkg::PWR_WAKE)
    begin
      next_stab_cnt  = 20'h0;
      next_stab_done = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst)
    begin
      stab_cnt  <= 20'h0;
      stab_done <= 1'b0;
    end
    else
    begin
      stab_cnt  <= next_stab_cnt;
      stab_done <= next_stab_done;
    end
  end

  assign stab_done_o = stab_done;

  // ==========================================================================
  // cpu hold after a reset, released once stabilization has elapsed
  // an interrupt wake clears stab_done too, but must not reset the cpu
  always_comb
  begin
    next_cpu_hold = cpu_hold && !stab_done;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst)
      cpu_hold <= 1'b1;
    else
      cpu_hold <= next_cpu_hold;
  end

  // ==========================================================================
  // cpu clock divider
  cpu_clock_divider u_div (
    .clk_i     (clk_i),
    .rst_i     (sys_rst),
    .div_sel_i (sysclk[clkrst_pkg::DIV_LO_BIT +: 2]),
    .run_i     (state == clkrst_pkg::PWR_RUN),
    .tick_o    (tick)
  );

  // clock gating per power state
  assign osc_enable_o    = (state != clkrst_pkg::PWR_STOP);
  assign cpu_clk_en_o    = tick;
  assign periph_clk_en_o = (state != clkrst_pkg::PWR_STOP);
  assign osc_pins_gpio_o = (osc_option_i == clkrst_pkg::OSC_INT_RC);
  assign reset_pin_gpio_o = lvr_option_i;

  // ==========================================================================
  // reset side effects toward cpu and peripherals
  assign reset_ctl_o.cpu_rst     = sys_rst || cpu_hold;
  assign reset_ctl_o.periph_rst  = sys_rst;
  assign reset_ctl_o.wdog_en     = sys_rst;
  assign reset_ctl_o.ports_input = sys_rst;
  assign reset_ctl_o.irq_disable = sys_rst;
  assign reset_pc_o              = clkrst_pkg::RESET_VECTOR;

endmodule

/* File: dv/clock_reset_power_control_sva.sv */
// assertion checker for the clock, reset and power control block
`timescale 1ns/10ps
module clock_reset_power_control_sva (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   cyc_i,
  input wire logic                   stb_i,
  input wire logic                   ack_o,
  input wire logic [1:0]             osc_option_i,
  input wire logic                   lvr_option_i,
  input wire logic                   external_reset_pin_n_i,
  input wire logic                   low_voltage_detector_reset_i,
  input wire logic                   wdog_overflow_i,
  input wire logic                   osc_enable_o,
  input wire logic                   osc_pins_gpio_o,
  input wire logic                   reset_pin_gpio_o,
  input wire logic                   cpu_clk_en_o,
  input wire logic                   periph_clk_en_o,
  input wire logic                   stab_done_o,
  input wire clkrst_pkg::reset_ctl_t reset_ctl_o,
  input wire logic                   wdog_reset_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ====================
  // bus handshake
  ack_once_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");

  // ====================
  // option pins and clock gating
  osc_gpio_a: assert property ($stable(osc_option_i)[*2] |->
    osc_pins_gpio_o == (osc_option_i == clkrst_pkg::OSC_INT_RC))
    else $error("oscillator pin release wrong");
  pin_gpio_a: assert property ($stable(lvr_option_i)[*2] |->
    reset_pin_gpio_o == lvr_option_i)
    else $error("reset pin release wrong");
  stop_halt_a: assert property (!osc_enable_o |->
    !periph_clk_en_o && !cpu_clk_en_o)
    else $error("clocks run with oscillator off");

  // ====================
  // reset sources
  lvd_hold_a: assert property ((lvr_option_i && low_voltage_detector_reset_i)[*2] |->
    reset_ctl_o.cpu_rst)
    else $error("no reset while supply low");
  pin_reset_a: assert property (!lvr_option_i && !external_reset_pin_n_i |->
    ##[0:4] reset_ctl_o.cpu_rst)
    else $error("pin low gave no reset");
  wdog_reset_a: assert property (wdog_overflow_i && wdog_reset_en_o |->
    ##[0:3] reset_ctl_o.cpu_rst)
    else $error("overflow gave no reset");
  rst_state_a: assert property (reset_ctl_o.periph_rst |->
    reset_ctl_o.irq_disable && reset_ctl_o.ports_input)
    else $error("reset leaves irq or ports live");
  cpu_hold_a: assert property (reset_ctl_o.cpu_rst && !stab_done_o |=>
    reset_ctl_o.cpu_rst || stab_done_o)
    else $error("cpu released before stabilization");

  // ====================
  // main scenarios
  stop_c: cover property (!osc_enable_o);
  stab_c: cover property ($rose(stab_done_o));
  wdog_c: cover property (wdog_overflow_i && wdog_reset_en_o);
endmodule

bind clock_reset_power_control clock_reset_power_control_sva chk_u (.clk_i, .rst_i, .cyc_i,
  .stb_i, .ack_o, .osc_option_i, .lvr_option_i, .external_reset_pin_n_i,
  .low_voltage_detector_reset_i, .wdog_overflow_i, .osc_enable_o, .osc_pins_gpio_o,
  .reset_pin_gpio_o, .cpu_clk_en_o, .periph_clk_en_o, .stab_done_o, .reset_ctl_o,
  .wdog_reset_en_o);

/* File: dv/reset_circuit_model.sv */
// external reset circuit driving the active low reset pin
`timescale 1ns/10ps
module reset_circuit_model #(
  parameter int HOLD = 64
) (
  input  wire logic clk_i,
  input  wire logic press_i,
  output logic      pin_n_o
);
  int cnt = 0;

  // ====================
  // hold the pin low for the stabilization span, then pull up
  always_ff @(posedge clk_i)
  begin
    if (press_i)
      cnt <= HOLD;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign pin_n_o = (cnt == 0);
endmodule

/* File: dv/clock_reset_power_control_bench.sv */
// self-checking bench for the clock, reset and power control block
`timescale 1ns/10ps
module clock_reset_power_control_bench;
  logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, press = 0, pin_n;
  logic        low_voltage_detector_reset = 0, lvd = 0, wdog = 0, irq_a = 0, irq_b = 0, irq_in = 0;
  logic [1:0]  osc = 0;
  logic [7:0]  adr = 0, wdat = 0, dat_o, rd, r;
  logic        ack_o, osc_en, osc_gpio, pin_gpio, cpu_en, per_en, stab, wen, seen;
  logic [15:0] pc;
  clkrst_pkg::reset_ctl_t rc;
  int          n_mismatch = 0, n_checks = 0, p;
  logic [31:0] seed = 94;
  localparam logic [7:0] CLK = clkrst_pkg::SYSTEM_CLOCK_CONTROL_ADDR;
  localparam logic [7:0] BT = clkrst_pkg::BASIC_TIMER_CONTROL_ADDR;
  localparam logic [7:0] CMD = clkrst_pkg::POWER_COMMAND_ADDR;

  clock_reset_power_control #(.STAB_WAIT(64)) dut_u (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(cyc),
    .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(1'b1), .dat_o, .ack_o, .osc_option_i(osc),
    .lvr_option_i(low_voltage_detector_reset), .external_reset_pin_n_i(pin_n), .low_voltage_detector_reset_i(lvd),
    .wdog_overflow_i(wdog), .external_irq_line_a_i(irq_a), .external_irq_line_b_i(irq_b),
    .internal_irq_i(irq_in), .osc_enable_o(osc_en), .osc_pins_gpio_o(osc_gpio),
    .reset_pin_gpio_o(pin_gpio), .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en),
    .stab_done_o(stab), .reset_ctl_o(rc), .reset_pc_o(pc), .wdog_reset_en_o(wen));
  reset_circuit_model #(.HOLD(64)) far_u (.clk_i, .press_i(press), .pin_n_o(pin_n));

  // ====================
  // clock and helpers
  always #10 clk_i = ~clk_i;

  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic int exp_period(logic [1:0] d);
    return d == 0 ? 16 : d == 1 ? 8 : d == 2 ? 2 : 1;
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(logic w, logic [7:0] a, logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 0;
    if (n >= 20)
    begin
      n_mismatch++;
      end_sim();
    end
  endtask

  task automatic wait_stab();
    int n;
    for (n = 0; n < 300 && stab === 1'b1; n++) @(posedge clk_i);
    for (n = 0; n < 300 && stab !== 1'b1; n++) @(posedge clk_i);
    chk(stab, 1);
    if (stab !== 1'b1)
      end_sim();
  endtask

  task automatic wait_run();
    int n;
    n = 0;
    do
    begin
      wb(0, clkrst_pkg::POWER_STATUS_ADDR, 0);
      n++;
    end
    while (rd[1:0] !== 2'h0 && n < 100);
    chk(rd[1:0], 0);
    if (rd[1:0] !== 2'h0)
      end_sim();
  endtask

  task automatic period();
    repeat (2)
    begin
      p = 0;
      do
      begin
        @(posedge clk_i);
        p++;
      end
      while (cpu_en !== 1'b1 && p < 100);
      if (p >= 100)
      begin
        n_mismatch++;
        end_sim();
      end
    end
  endtask

  // ====================
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    wait_stab();
    wb(0, CLK, 0);
    chk(rd, clkrst_pkg::SYSCLK_RESET);
    chk(pc, clkrst_pkg::RESET_VECTOR);
    chk(rc.cpu_rst, 0);
    wb(0, 8'hd3, 0);
    chk(rd, 0);
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      r[4:3] = i[1:0];
      wb(1, CLK, r);
      wb(0, CLK, 0);
      chk(rd, r & 8'h98);
      period();
      chk(16'(p), 16'(exp_period(i[1:0])));
    end
    wb(1, CLK, 8'h88);
    wb(1, CMD, clkrst_pkg::CMD_IDLE);
    wb(0, clkrst_pkg::POWER_STATUS_ADDR, 0);
    chk(rd[1:0], 1);
    seen = 0;
    repeat (20) @(posedge clk_i) seen |= cpu_en;
    chk({seen, per_en, osc_en}, 3'b011);
    irq_in <= 1;
    wait_run();
    irq_in <= 0;
    wb(1, BT, 8'h04);
    wb(1, clkrst_pkg::STOP_ENABLE_CONTROL_ADDR, clkrst_pkg::STOP_KEY);
    wb(1, CMD, clkrst_pkg::CMD_STOP);
    irq_in <= 1;
    repeat (5) @(posedge clk_i);
    chk({osc_en, per_en}, 0);
    wb(0, clkrst_pkg::POWER_STATUS_ADDR, 0);
    chk(rd[1:0], 2);
    irq_in <= 0;
    irq_b <= 1;
    wait_run();
    irq_b <= 0;
    chk(rc.cpu_rst, 0);
    wb(0, CLK, 0);
    chk(rd, 8'h88);
    wb(1, clkrst_pkg::STOP_ENABLE_CONTROL_ADDR, 0);
    wb(1, CMD, clkrst_pkg::CMD_STOP);
    wait_stab();
    wb(0, CLK, 0);
    chk(rd, clkrst_pkg::SYSCLK_RESET);
    wb(1, BT, 8'ha0);
    chk(wen, 0);
    wb(1, BT, 0);
    chk(wen, 1);
    wb(1, CLK, 8'h98);
    wdog <= 1;
    @(posedge clk_i) wdog <= 0;
    wait_stab();
    wb(0, CLK, 0);
    chk(rd, clkrst_pkg::SYSCLK_RESET);
    wb(1, CLK, 8'h98);
    press <= 1;
    @(posedge clk_i) press <= 0;
    repeat (8) @(posedge clk_i);
    chk({rc.cpu_rst, rc.irq_disable, rc.ports_input, rc.wdog_en, rc.periph_rst}, 5'h1f);
    wait_stab();
    wb(0, CLK, 0);
    chk(rd, clkrst_pkg::SYSCLK_RESET);
    low_voltage_detector_reset <= 1;
    lvd <= 1;
    repeat (10) @(posedge clk_i);
    chk({rc.cpu_rst, pin_gpio}, 2'b11);
    lvd <= 0;
    wait_stab();
    foreach (osc[i])
    begin
      osc <= {i[0], 1'b1};
      repeat (3) @(posedge clk_i);
      chk(osc_gpio, i == 1);
    end
    end_sim();
  end
endmodule
